/* File: core/motion_regs_pkg.sv */
// Package: register map, field layouts and reset values of the motion offset/rate bank
package motion_regs_pkg;

    localparam int REG_W = 8;
    localparam int AXIS_W = 16;
    localparam int ADDR_W = 8;
    localparam int INDEX_W = 5;

    // Printed offsets are register indices; byte address is index times four
    localparam logic [INDEX_W-1:0] IDX_GYRO_X_ST = 5'h00;
    localparam logic [INDEX_W-1:0] IDX_GYRO_Y_ST = 5'h01;
    localparam logic [INDEX_W-1:0] IDX_GYRO_Z_ST = 5'h02;
    localparam logic [INDEX_W-1:0] IDX_ACCEL_X_ST = 5'h0d;
    localparam logic [INDEX_W-1:0] IDX_ACCEL_Y_ST = 5'h0e;
    localparam logic [INDEX_W-1:0] IDX_ACCEL_Z_ST = 5'h0f;
    localparam logic [INDEX_W-1:0] IDX_GYRO_X_BIAS_HIGH = 5'h13;
    localparam logic [INDEX_W-1:0] IDX_GYRO_X_BIAS_LOW = 5'h14;
    localparam logic [INDEX_W-1:0] IDX_GYRO_Y_BIAS_HIGH = 5'h15;
    localparam logic [INDEX_W-1:0] IDX_GYRO_Y_BIAS_LOW = 5'h16;
    localparam logic [INDEX_W-1:0] IDX_GYRO_Z_BIAS_HIGH = 5'h17;
    localparam logic [INDEX_W-1:0] IDX_GYRO_Z_BIAS_LOW = 5'h18;
    localparam logic [INDEX_W-1:0] IDX_OUTPUT_RATE_DIVISOR = 5'h19;
    // Filter setting and status registers not held by the printed map
    localparam logic [INDEX_W-1:0] IDX_FILTER_CFG = 5'h1a;
    localparam logic [INDEX_W-1:0] IDX_RATE_STATUS = 5'h1b;

    // Filter setting fields
    localparam int LOWPASS_LSB = 0;
    localparam int BYPASS_LSB = 3;
    localparam logic [2:0] LOWPASS_MAX = 3'h7;
    localparam logic [2:0] LOWPASS_MIN = 3'h0;
    localparam logic [1:0] FILTER_CHOICE_ON = 2'b11;

    // Reset values
    localparam logic [REG_W-1:0] DIVISOR_RESET = 8'h00;
    localparam logic [REG_W-1:0] ZERO_RESET = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Time constants
    localparam real CLOCK_MHZ = 125.0;
    localparam real BASE_RATE_KHZ = 1.0;
    localparam int BASE_PERIOD_CYCLES = int'(CLOCK_MHZ * 1000.0 / BASE_RATE_KHZ);

    typedef struct packed {
        logic [AXIS_W-1:0] x;
        logic [AXIS_W-1:0] y;
        logic [AXIS_W-1:0] z;
    } axis_triplet_type;

    typedef struct packed {
        logic [REG_W-1:0] gx;
        logic [REG_W-1:0] gy;
        logic [REG_W-1:0] gz;
        logic [REG_W-1:0] ax;
        logic [REG_W-1:0] ay;
        logic [REG_W-1:0] az;
    } selftest_set_type;

endpackage

/* File: core/output_rate_divider.sv */
// Sample divider: counts base-rate strobes and emits the output sample strobe
`timescale 1ns/100ps
module output_rate_divider #(
    parameter int BASE_CYCLES = motion_regs_pkg::BASE_PERIOD_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Control
    input wire logic divide_enable,
    input wire logic [motion_regs_pkg::REG_W-1:0] sample_divisor,
    // Strobes
    output logic base_strobe,
    output logic sample_strobe
);
    import motion_regs_pkg::*;

    localparam int TICK_W = $clog2(BASE_CYCLES + 1);

    // Refused at elaboration: the tick counter needs at least two states
    if (BASE_CYCLES < 2)
    begin : g_base_check
        $error("BASE_CYCLES must be at least 2");
    end

    logic [TICK_W-1:0] tick_reg;
    logic [TICK_W-1:0] tick_next;
    logic [REG_W-1:0] div_count_reg;
    logic [REG_W-1:0] div_count_next;
    logic base_strobe_reg;
    logic sample_strobe_reg;
    logic base_hit;
    logic div_hit;

    assign base_hit = (tick_reg == TICK_W'(BASE_CYCLES - 1));
    assign tick_next = base_hit ? '0 : tick_reg + 1'b1;
    // Divisor ignored outside the low-pass path: every base strobe passes
    assign div_hit = !divide_enable || (div_count_reg >= sample_divisor);
    assign div_count_next = !base_hit ? div_count_reg : (div_hit ? '0 : div_count_reg + 1'b1);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            tick_reg <= '0;
            div_count_reg <= '0;
            base_strobe_reg <= 1'b0;
            sample_strobe_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= tick_next;
            div_count_reg <= div_count_next;
            base_strobe_reg <= base_hit;
            sample_strobe_reg <= base_hit && div_hit;
        end
    end

    assign base_strobe = base_strobe_reg;
    assign sample_strobe = sample_strobe_reg;

endmodule

/* File: core/motion_offset_rate_regs.sv */
// Register bank: factory self-test bytes, gyro bias, sample divisor, AXI4-Lite slave
// Functional notes
// - Six read/write factory self-test bytes
// - Gyro bias is 16-bit split high/low
// - Bias added to raw gyro before output
// - Output rate is base over divisor plus one
// - Divisor used only on low-pass path
// - Divided strobe updates outputs and FIFO push
// - Divisor read/write, resets to zero
// - Filter choice is inverse of bypass select
// - Self-test bytes reset to factory values
`timescale 1ns/100ps
module motion_offset_rate_regs #(
    parameter int BASE_CYCLES = motion_regs_pkg::BASE_PERIOD_CYCLES,
    // Factory trim values; arbitrary defaults
    parameter logic [7:0] FACTORY_GYRO_X = 8'h00,
    parameter logic [7:0] FACTORY_GYRO_Y = 8'h00,
    parameter logic [7:0] FACTORY_GYRO_Z = 8'h00,
    parameter logic [7:0] FACTORY_ACCEL_X = 8'h00,
    parameter logic [7:0] FACTORY_ACCEL_Y = 8'h00,
    parameter logic [7:0] FACTORY_ACCEL_Z = 8'h00
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // AXI4-Lite write address and data
    input wire logic [motion_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [motion_regs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Raw gyro samples from the sensor front end, same clock
    input wire motion_regs_pkg::axis_triplet_type raw_gyro,
    // Corrected gyro outputs and strobes
    output motion_regs_pkg::axis_triplet_type gyro_out,
    output logic sample_strobe,
    output logic fifo_push
);
    import motion_regs_pkg::*;

    typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_type;
    typedef enum logic [1:0] {RD_IDLE, RD_DATA} rd_state_type;

    // Index from byte address; misaligned or out-of-range addresses are unmapped
    function automatic logic [INDEX_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
        addr_index = a[INDEX_W+1:2];
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic [INDEX_W-1:0] i;
        i = a[INDEX_W+1:2];
        addr_mapped = (a[1:0] == 2'b00) && (a[ADDR_W-1:INDEX_W+2] == '0)
            && ((i <= IDX_GYRO_Z_ST)
            || (i >= IDX_ACCEL_X_ST && i <= IDX_ACCEL_Z_ST)
            || (i >= IDX_GYRO_X_BIAS_HIGH && i <= IDX_RATE_STATUS));
    endfunction

    selftest_set_type selftest_reg;
    axis_triplet_type bias_reg;
    logic [REG_W-1:0] divisor_reg;
    logic [1:0] bypass_reg;
    logic [2:0] lowpass_reg;
    axis_triplet_type gyro_out_reg;
    logic fifo_push_reg;
    logic sample_strobe_reg;
    logic sample_seen_reg;
    wr_state_type wr_state_reg;
    rd_state_type rd_state_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [REG_W-1:0] wbyte_reg;
    logic wlane_reg;
    logic aw_have_reg;
    logic w_have_reg;

    logic [1:0] filter_choice;
    logic divide_enable;
    logic div_strobe;
    logic aw_take;
    logic w_take;
    logic aw_now;
    logic w_now;
    logic do_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [REG_W-1:0] wr_byte;
    logic wr_lane;
    logic [INDEX_W-1:0] wr_idx;
    logic wr_ok;
    logic [INDEX_W-1:0] rd_idx;
    logic rd_ok;
    logic [REG_W-1:0] rd_byte;
    axis_triplet_type corrected;

    // Filter choice is the inverse of the bypass field
    assign filter_choice = ~bypass_reg;
    assign divide_enable = (filter_choice == FILTER_CHOICE_ON)
        && (lowpass_reg > LOWPASS_MIN) && (lowpass_reg < LOWPASS_MAX);

    output_rate_divider #(
        .BASE_CYCLES(BASE_CYCLES)
    ) u_divider (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .divide_enable(divide_enable),
        .sample_divisor(divisor_reg),
        .base_strobe(),
        .sample_strobe(div_strobe)
    );

    // Wraps on overflow, as two's-complement hardware does
    assign corrected.x = raw_gyro.x + bias_reg.x;
    assign corrected.y = raw_gyro.y + bias_reg.y;
    assign corrected.z = raw_gyro.z + bias_reg.z;

    // Write channel: address and data taken in either order
    assign aw_take = s_axi_awvalid && awready_reg;
    assign w_take = s_axi_wvalid && wready_reg;
    assign aw_now = aw_have_reg || aw_take;
    assign w_now = w_have_reg || w_take;
    assign do_write = (wr_state_reg == WR_IDLE) && aw_now && w_now;
    assign wr_addr = aw_have_reg ? awaddr_reg : s_axi_awaddr;
    assign wr_byte = w_have_reg ? wbyte_reg : s_axi_wdata[REG_W-1:0];
    assign wr_lane = w_have_reg ? wlane_reg : s_axi_wstrb[0];
    assign wr_idx = addr_index(wr_addr);
    assign wr_ok = addr_mapped(wr_addr);

    assign rd_idx = addr_index(s_axi_araddr);
    assign rd_ok = addr_mapped(s_axi_araddr);

    always_comb
    begin
        rd_byte = ZERO_RESET;
        unique case (rd_idx)
            IDX_GYRO_X_ST: rd_byte = selftest_reg.gx;
            IDX_GYRO_Y_ST: rd_byte = selftest_reg.gy;
            IDX_GYRO_Z_ST: rd_byte = selftest_reg.gz;
            IDX_ACCEL_X_ST: rd_byte = selftest_reg.ax;
            IDX_ACCEL_Y_ST: rd_byte = selftest_reg.ay;
            IDX_ACCEL_Z_ST: rd_byte = selftest_reg.az;
            IDX_GYRO_X_BIAS_HIGH: rd_byte = bias_reg.x[15:8];
            IDX_GYRO_X_BIAS_LOW: rd_byte = bias_reg.x[7:0];
            IDX_GYRO_Y_BIAS_HIGH: rd_byte = bias_reg.y[15:8];
            IDX_GYRO_Y_BIAS_LOW: rd_byte = bias_reg.y[7:0];
            IDX_GYRO_Z_BIAS_HIGH: rd_byte = bias_reg.z[15:8];
            IDX_GYRO_Z_BIAS_LOW: rd_byte = bias_reg.z[7:0];
            IDX_OUTPUT_RATE_DIVISOR: rd_byte = divisor_reg;
            IDX_FILTER_CFG: rd_byte = {3'b000, bypass_reg, lowpass_reg};
            IDX_RATE_STATUS: rd_byte = {6'b00_0000, sample_seen_reg, divide_enable};
            default: rd_byte = ZERO_RESET;
        endcase
    end

    // Write handshake
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            wr_state_reg <= WR_IDLE;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= '0;
            wbyte_reg <= '0;
            wlane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else
        begin
            unique case (wr_state_reg)
                WR_IDLE:
                begin
                    if (aw_take)
                    begin
                        awaddr_reg <= s_axi_awaddr;
                        aw_have_reg <= 1'b1;
                        awready_reg <= 1'b0;
                    end
                    if (w_take)
                    begin
                        wbyte_reg <= s_axi_wdata[REG_W-1:0];
                        wlane_reg <= s_axi_wstrb[0];
                        w_have_reg <= 1'b1;
                        wready_reg <= 1'b0;
                    end
                    if (do_write)
                    begin
                        aw_have_reg <= 1'b0;
                        w_have_reg <= 1'b0;
                        awready_reg <= 1'b0;
                        wready_reg <= 1'b0;
                        bvalid_reg <= 1'b1;
                        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                        wr_state_reg <= WR_RESP;
                    end
                end
                WR_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        bvalid_reg <= 1'b0;
                        awready_reg <= 1'b1;
                        wready_reg <= 1'b1;
                        wr_state_reg <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // Register contents; a clear byte lane 0 drops the write but still answers OKAY
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            selftest_reg <= {FACTORY_GYRO_X, FACTORY_GYRO_Y, FACTORY_GYRO_Z,
                FACTORY_ACCEL_X, FACTORY_ACCEL_Y, FACTORY_ACCEL_Z};
            bias_reg <= '0;
            divisor_reg <= DIVISOR_RESET;
            bypass_reg <= 2'b00;
            lowpass_reg <= 3'b000;
        end
        else if (do_write && wr_ok && wr_lane)
        begin
            unique case (wr_idx)
                IDX_GYRO_X_ST: selftest_reg.gx <= wr_byte;
                IDX_GYRO_Y_ST: selftest_reg.gy <= wr_byte;
                IDX_GYRO_Z_ST: selftest_reg.gz <= wr_byte;
                IDX_ACCEL_X_ST: selftest_reg.ax <= wr_byte;
                IDX_ACCEL_Y_ST: selftest_reg.ay <= wr_byte;
                IDX_ACCEL_Z_ST: selftest_reg.az <= wr_byte;
                IDX_GYRO_X_BIAS_HIGH: bias_reg.x[15:8] <= wr_byte;
                IDX_GYRO_X_BIAS_LOW: bias_reg.x[7:0] <= wr_byte;
                IDX_GYRO_Y_BIAS_HIGH: bias_reg.y[15:8] <= wr_byte;
                IDX_GYRO_Y_BIAS_LOW: bias_reg.y[7:0] <= wr_byte;
                IDX_GYRO_Z_BIAS_HIGH: bias_reg.z[15:8] <= wr_byte;
                IDX_GYRO_Z_BIAS_LOW: bias_reg.z[7:0] <= wr_byte;
                IDX_OUTPUT_RATE_DIVISOR: divisor_reg <= wr_byte;
                IDX_FILTER_CFG:
                begin
                    lowpass_reg <= wr_byte[LOWPASS_LSB +: 3];
                    bypass_reg <= wr_byte[BYPASS_LSB +: 2];
                end
                default:
                begin
                end
            endcase
        end
    end

    // Read handshake
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rd_state_reg <= RD_IDLE;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end
        else
        begin
            unique case (rd_state_reg)
                RD_IDLE:
                begin
                    if (s_axi_arvalid)
                    begin
                        arready_reg <= 1'b0;
                        rvalid_reg <= 1'b1;
                        rdata_reg <= {24'h00_0000, rd_byte};
                        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                        rd_state_reg <= RD_DATA;
                    end
                end
                RD_DATA:
                begin
                    if (s_axi_rready)
                    begin
                        rvalid_reg <= 1'b0;
                        arready_reg <= 1'b1;
                        rd_state_reg <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    // Sample path: output and FIFO push share the divided strobe
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            gyro_out_reg <= '0;
            fifo_push_reg <= 1'b0;
            sample_strobe_reg <= 1'b0;
            sample_seen_reg <= 1'b0;
        end
        else
        begin
            fifo_push_reg <= div_strobe;
            sample_strobe_reg <= div_strobe;
            if (div_strobe)
            begin
                gyro_out_reg <= corrected;
                sample_seen_reg <= ~sample_seen_reg;
            end
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign gyro_out = gyro_out_reg;
    assign sample_strobe = sample_strobe_reg;
    assign fifo_push = fifo_push_reg;

endmodule

/* File: testbench/motion_offset_rate_regs_props.sv */
// Checker: bus handshake and sample strobe properties of the register bank
`timescale 1ns/100ps
module motion_offset_rate_regs_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sample path
    input wire motion_regs_pkg::axis_triplet_type gyro_out,
    input wire logic sample_strobe,
    input wire logic fifo_push
);
    import motion_regs_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Holds only while the base period stays above eight cycles
    sequence pulse_gap;
        sample_strobe ##1 !sample_strobe [*8];
    endsequence
    a_write_answer: assert property (wr_taken |=> s_axi_bvalid && !s_axi_awready)
        else $error("write response late");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_byte_only: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data above low byte");
    a_push_tracks: assert property (fifo_push == sample_strobe)
        else $error("push differs from sample strobe");
    a_pulse_gap: assert property (sample_strobe |-> pulse_gap)
        else $error("sample strobes too close");
    a_output_holds: assert property (!sample_strobe |-> $stable(gyro_out))
        else $error("gyro output moved between samples");
endmodule

bind motion_offset_rate_regs motion_offset_rate_regs_props u_motion_offset_rate_regs_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gyro_out(gyro_out),
    .sample_strobe(sample_strobe), .fifo_push(fifo_push));

/* File: testbench/motion_offset_rate_regs_tb.sv */
// Testbench: register access, bias addition and output rate of the register bank
`timescale 1ns/100ps
module motion_offset_rate_regs_tb;
    import motion_regs_pkg::*;
    localparam int BASE = 10;
    localparam int LIMIT = 4000;
    // Factory bytes are arbitrary
    localparam logic [7:0] RST_TAB [13] = '{8'h5a, 8'hc3, 8'h17, 8'h8e, 8'h21, 8'hf4,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [4:0] IDX_TAB [13] = '{IDX_GYRO_X_ST, IDX_GYRO_Y_ST, IDX_GYRO_Z_ST,
        IDX_ACCEL_X_ST, IDX_ACCEL_Y_ST, IDX_ACCEL_Z_ST, IDX_GYRO_X_BIAS_HIGH,
        IDX_GYRO_X_BIAS_LOW, IDX_GYRO_Y_BIAS_HIGH, IDX_GYRO_Y_BIAS_LOW,
        IDX_GYRO_Z_BIAS_HIGH, IDX_GYRO_Z_BIAS_LOW, IDX_OUTPUT_RATE_DIVISOR};
    // Filter setting, divisor and base ticks per sample
    localparam logic [7:0] CFG_TAB [9] = '{8'h01, 8'h06, 8'h00, 8'h07, 8'h09, 8'h11, 8'h19,
        8'h01, 8'h01};
    localparam logic [7:0] DIV_TAB [9] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03,
        8'h00, 8'hff};
    localparam int MUL_TAB [9] = '{4, 4, 1, 1, 1, 1, 1, 1, 256};
    localparam logic [47:0] BIAS = 48'h1234_ff00_8001;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    axis_triplet_type raw_gyro = '0;
    axis_triplet_type gyro_out;
    logic sample_strobe;
    logic fifo_push;
    int bad_count = 0;
    int num_checks = 0;

    motion_offset_rate_regs #(.BASE_CYCLES(BASE), .FACTORY_GYRO_X(RST_TAB[0]),
        .FACTORY_GYRO_Y(RST_TAB[1]), .FACTORY_GYRO_Z(RST_TAB[2]),
        .FACTORY_ACCEL_X(RST_TAB[3]), .FACTORY_ACCEL_Y(RST_TAB[4]),
        .FACTORY_ACCEL_Z(RST_TAB[5])) u_motion_offset_rate_regs (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .raw_gyro(raw_gyro), .gyro_out(gyro_out),
        .sample_strobe(sample_strobe), .fifo_push(fifo_push));

    always #4 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic hang();
        bad_count++;
        wrap_up();
    endtask

    function automatic logic [7:0] addr_of(input logic [4:0] idx);
        return {1'b0, idx, 2'b00};
    endfunction

    // Response ready comes only after the response, so the slave must hold it meanwhile
    task automatic bus_write(input logic [7:0] addr, input logic [7:0] data,
        input logic [3:0] strb, input logic [1:0] resp);
        int n;
        @(posedge ref_clk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= {24'h00_0000, data};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < LIMIT; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
                break;
            if (s_axi_bvalid === 1'b1)
                s_axi_bready <= 1'b1;
        end
        if (n == LIMIT)
            hang();
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, resp});
    endtask

    task automatic bus_read(input logic [7:0] addr, input logic [7:0] data,
        input logic [1:0] resp);
        int n;
        @(posedge ref_clk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < LIMIT; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
                break;
            if (s_axi_rvalid === 1'b1)
                s_axi_rready <= 1'b1;
        end
        if (n == LIMIT)
            hang();
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, {24'h00_0000, data});
        check({30'h0, s_axi_rresp}, {30'h0, resp});
    endtask

    task automatic wait_strobe(output int cycles);
        for (cycles = 1; cycles < LIMIT; cycles++)
        begin
            @(posedge ref_clk);
            if (sample_strobe === 1'b1)
                break;
        end
        if (cycles == LIMIT)
            hang();
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
    endtask

    task automatic check_resets();
        for (int i = 0; i < 13; i++)
            bus_read(addr_of(IDX_TAB[i]), RST_TAB[i], RESP_OKAY);
    endtask

    initial
    begin
        int seen;
        do_reset();
        check_resets();
        for (int i = 0; i < 13; i++)
        begin
            bus_write(addr_of(IDX_TAB[i]), 8'h3c ^ 8'(i), 4'h1, RESP_OKAY);
            bus_read(addr_of(IDX_TAB[i]), 8'h3c ^ 8'(i), RESP_OKAY);
        end
        // Cleared byte strobe, unmapped and misaligned places must leave bytes alone
        bus_write(addr_of(IDX_GYRO_X_ST), 8'hff, 4'h0, RESP_OKAY);
        bus_read(addr_of(IDX_GYRO_X_ST), 8'h3c, RESP_OKAY);
        bus_write(8'h0c, 8'h55, 4'h1, RESP_SLVERR);
        bus_read(8'h0c, 8'h00, RESP_SLVERR);
        bus_write(8'h4d, 8'h55, 4'h1, RESP_SLVERR);
        bus_read(addr_of(IDX_GYRO_X_BIAS_HIGH), 8'h3a, RESP_OKAY);
        do_reset();
        check_resets();
        for (int i = 0; i < 6; i++)
            bus_write(addr_of(IDX_TAB[6 + i]), BIAS[47 - 8 * i -: 8], 4'h1, RESP_OKAY);
        raw_gyro <= 48'h0010_0005_7fff;
        // First strobe may still carry the old raw sample
        repeat (2) wait_strobe(seen);
        check(32'(fifo_push), 32'h0000_0001);
        check({16'h0000, gyro_out.x}, 32'h0000_1244);
        check({16'h0000, gyro_out.y}, 32'h0000_ff05);
        check({16'h0000, gyro_out.z}, 32'h0000_0000);
        for (int i = 0; i < 9; i++)
        begin
            bus_write(addr_of(IDX_OUTPUT_RATE_DIVISOR), DIV_TAB[i], 4'h1, RESP_OKAY);
            bus_write(addr_of(IDX_FILTER_CFG), CFG_TAB[i], 4'h1, RESP_OKAY);
            bus_read(addr_of(IDX_FILTER_CFG), CFG_TAB[i], RESP_OKAY);
            repeat (3) wait_strobe(seen);
            check(32'(seen), 32'(BASE * MUL_TAB[i]));
            check(32'(fifo_push), 32'h0000_0001);
            check({16'h0000, gyro_out.x}, 32'h0000_1244);
        end
        wrap_up();
    end
endmodule
